// ==== src/crf_pkg.sv ====
package crf_pkg;
  localparam int unsigned CRF_WORDS = 128;
  localparam int unsigned CRF_AW = 7;
  localparam int unsigned CRF_DW = 16;
  // response word offsets
  localparam logic [6:0] CRF_OFS_ERR = 7'h00;
  localparam logic [6:0] CRF_OFS_STATION = 7'h01;
  localparam logic [6:0] CRF_OFS_DET1 = 7'h02;
  localparam logic [6:0] CRF_OFS_DET2 = 7'h03;
  localparam logic [6:0] CRF_OFS_DET3 = 7'h04;
  localparam logic [6:0] CRF_OFS_DIAG = 7'h07;
  localparam logic [6:0] CRF_OFS_LAST = 7'h7F;
  // field positions in the diagnostic word
  localparam int unsigned CRF_DTYPE_LSB = 8;
  localparam int unsigned CRF_DLEN_LSB = 0;
  // values
  localparam logic [15:0] CRF_REJECT_CODE = 16'hE482;
  localparam logic [15:0] CRF_NO_DETAIL = 16'hFFFF;
  localparam logic [15:0] CRF_ZERO = 16'h0000;
  localparam logic [6:0] CRF_STATION_MAX = 7'h7D;

  typedef struct packed {
    logic ok;
    logic [15:0] err_code;
    logic [6:0] station;
    logic [15:0] detail1;
    logic [15:0] detail2;
    logic [15:0] detail3;
    logic [7:0] diag_type;
    logic [7:0] diag_len;
  } crf_req_t;

  typedef enum logic [1:0] {
    CRF_IDLE = 2'b00,
    CRF_FILL = 2'b01,
    CRF_DONE = 2'b10
  } crf_state_t;
endpackage

// ==== src/crf_resp_ram.sv ====
`timescale 1ns/1ns
module crf_resp_ram #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  always_comb begin
    rdata_d = mem[i_raddr];
  end

  // array has no reset; only the read register does
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    if (!i_resetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
endmodule

// ==== src/crf_formatter.sv ====
`timescale 1ns/1ns
// How it works
// R01: on success, word 7 holds the diagnostic type byte in its high half and the diagnostic length byte in its low half.
// R02: on success, words 8 to 127 are written as zero.
// R03: on failure, word 0 holds the error code.
// R04: on failure, word 1 holds the target station number, 0 to 125; the code stores any 7-bit number as given, 126 and 127 included.
// R05: on failure, word 2 holds detail code 1 only for the rejection code, all ones otherwise.
// R06: on failure, word 3 holds detail code 2 only for the rejection code, all ones otherwise.
// R07: on failure, word 4 holds detail code 3 only for the rejection code, all ones otherwise.
// R08: on failure, words 5 to 127 are written as zero.
// R09: completion is signalled only after all 128 words have been written.
module crf_formatter (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire crf_pkg::crf_req_t i_req,
  input wire logic [crf_pkg::CRF_AW-1:0] i_rd_addr,
  output logic [crf_pkg::CRF_DW-1:0] o_rd_data,
  output logic o_busy,
  output logic o_done
);
  import crf_pkg::*;

  // control group: phase of the job and the index of the word being written
  crf_state_t state_q;
  crf_state_t state_d;
  logic [CRF_AW-1:0] idx_q;
  logic [CRF_AW-1:0] idx_d;

  // request group: private copy of the job, frozen for the whole fill
  crf_req_t req_q;
  crf_req_t req_d;

  // status group: the two flags the reading program polls
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;

  // shared decodes
  logic take;
  logic last;

  // write port of the response memory
  logic we;
  logic [CRF_AW-1:0] waddr;
  logic [CRF_DW-1:0] wdata;

  // the rejection code is the only one that carries detail words
  function automatic logic is_reject(input crf_req_t r);
    is_reject = (r.err_code == CRF_REJECT_CODE);
  endfunction

  function automatic logic [CRF_DW-1:0] detail_or_none(input crf_req_t r, input logic [CRF_DW-1:0] det);
    logic [CRF_DW-1:0] w;
    w = CRF_NO_DETAIL;
    if (is_reject(r)) begin
      w = det;
    end
    detail_or_none = w;
  endfunction

  // success layout: only the diagnostic word carries data, words 0..6 are cleared too
  function automatic logic [CRF_DW-1:0] ok_word(input crf_req_t r, input logic [CRF_AW-1:0] i);
    logic [CRF_DW-1:0] w;
    w = CRF_ZERO; // R02
    if (i == CRF_OFS_DIAG) begin
      w[CRF_DTYPE_LSB +: 8] = r.diag_type; // R01
      w[CRF_DLEN_LSB +: 8] = r.diag_len; // R01
    end
    ok_word = w;
  endfunction

  // failure layout: station is stored as given, out-of-range numbers are not filtered
  function automatic logic [CRF_DW-1:0] fail_word(input crf_req_t r, input logic [CRF_AW-1:0] i);
    logic [CRF_DW-1:0] w;
    w = CRF_ZERO;
    unique case (i)
      CRF_OFS_ERR: begin
        w = r.err_code; // R03
      end
      CRF_OFS_STATION: begin
        w = {9'h000, r.station}; // R04
      end
      CRF_OFS_DET1: begin
        w = detail_or_none(r, r.detail1); // R05
      end
      CRF_OFS_DET2: begin
        w = detail_or_none(r, r.detail2); // R06
      end
      CRF_OFS_DET3: begin
        w = detail_or_none(r, r.detail3); // R07
      end
      default: begin
        w = CRF_ZERO; // R08
      end
    endcase
    fail_word = w;
  endfunction

  // one word of the response for the captured job
  function automatic logic [CRF_DW-1:0] resp_word(input crf_req_t r, input logic [CRF_AW-1:0] i);
    logic [CRF_DW-1:0] w;
    if (r.ok) begin
      w = ok_word(r, i);
    end else begin
      w = fail_word(r, i);
    end
    resp_word = w;
  endfunction

  // a start while busy is ignored, so the job cannot change under a running fill
  always_comb begin
    take = (state_q == CRF_IDLE) && i_start;
    last = (state_q == CRF_FILL) && (idx_q == CRF_OFS_LAST);
  end

  // control group
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    unique case (state_q)
      CRF_IDLE: begin
        if (take) begin
          idx_d = '0;
          state_d = CRF_FILL;
        end
      end
      CRF_FILL: begin
        idx_d = idx_q + 7'h01;
        if (last) begin
          state_d = CRF_DONE; // R09
        end
      end
      CRF_DONE: begin
        state_d = CRF_IDLE;
      end
      default: begin
        state_d = CRF_IDLE;
        idx_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= CRF_IDLE;
      idx_q <= '0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
    end
  end

  // request group
  always_comb begin
    req_d = req_q;
    if (take) begin
      req_d = i_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  // status group: done only after the last word is in the memory
  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    unique case (state_q)
      CRF_IDLE: begin
        busy_d = take;
      end
      CRF_FILL: begin
        busy_d = 1'b1;
      end
      CRF_DONE: begin
        busy_d = 1'b0; // R09
        done_d = 1'b1; // R09
      end
      default: begin
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  // every fill writes all words, so no word of an earlier job survives
  always_comb begin
    we = (state_q == CRF_FILL); // R02 R08
    waddr = idx_q;
    wdata = resp_word(req_q, idx_q);
  end

  crf_resp_ram #(
    .AW(CRF_AW),
    .DW(CRF_DW)
  ) u_ram (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_we(we),
    .i_waddr(waddr),
    .i_wdata(wdata),
    .i_raddr(i_rd_addr),
    .o_rdata(o_rd_data)
  );

  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule

// ==== test/crf_formatter_assertions.sv ====
`timescale 1ns/1ns
module crf_formatter_assertions (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire crf_pkg::crf_req_t i_req,
  input wire logic [6:0] i_rd_addr,
  input wire logic [15:0] o_rd_data,
  input wire logic o_busy,
  input wire logic o_done
);
  import crf_pkg::*;
  crf_req_t r_q;
  logic v_q;
  logic rd;
  always_ff @(posedge i_clk) begin
    if (i_start && !o_busy && i_resetn) r_q <= i_req;
    v_q <= i_resetn && (v_q || o_done);
  end
  // the memory is not reset, so reads are judged only after a full fill
  assign rd = v_q && !o_busy && !i_start;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_busy_rise: assert property (i_start && !o_busy |=> o_busy) else $error("busy");
  a_done_time: assert property (i_start && !o_busy |-> ##130 o_done) else $error("done");
  a_done_end: assert property ($fell(o_busy) && $past(i_resetn) |-> o_done) else $error("end");
  a_done_once: assert property (o_done |=> !o_done) else $error("pulse");
  a_diag_word: assert property (rd && r_q.ok && i_rd_addr == 7 |=>
    o_rd_data == {r_q.diag_type, r_q.diag_len}) else $error("diag");
  a_zero_tail: assert property (rd && i_rd_addr >= 8 |=> o_rd_data == 16'h0000) else $error("zero");
  a_err_word: assert property (rd && !r_q.ok && i_rd_addr == 0 |=> o_rd_data == r_q.err_code) else $error("err");
  a_station_word: assert property (rd && !r_q.ok && i_rd_addr == 1 |=>
    o_rd_data == {9'h000, r_q.station}) else $error("station");
  a_det_one: assert property (rd && !r_q.ok && i_rd_addr == 2 |=>
    o_rd_data == (r_q.err_code == CRF_REJECT_CODE ? r_q.detail1 : CRF_NO_DETAIL)) else $error("det");
  a_det_two: assert property (rd && !r_q.ok && i_rd_addr == 3 |=>
    o_rd_data == (r_q.err_code == CRF_REJECT_CODE ? r_q.detail2 : CRF_NO_DETAIL)) else $error("det2");
  a_det_three: assert property (rd && !r_q.ok && i_rd_addr == 4 |=>
    o_rd_data == (r_q.err_code == CRF_REJECT_CODE ? r_q.detail3 : CRF_NO_DETAIL)) else $error("det3");
endmodule
bind crf_formatter crf_formatter_assertions chk_u (.i_clk, .i_resetn, .i_start, .i_req, .i_rd_addr,
  .o_rd_data, .o_busy, .o_done);

// ==== test/crf_reader.sv ====
`timescale 1ns/1ns
module crf_reader (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_rd_data,
  output logic [6:0] o_rd_addr,
  output logic [15:0] o_mem [128],
  output logic o_busy
);
  int n = 200;
  // data comes two edges after the address is set
  always @(posedge i_clk) begin
    if (i_go) n <= 0;
    else if (n < 130) n <= n + 1;
    if (n >= 2 && n < 130) o_mem[n-2] <= i_rd_data;
    o_rd_addr <= (n < 128) ? n[6:0] : 7'h00;
  end
  assign o_busy = n < 130;
endmodule

// ==== test/crf_formatter_tb.sv ====
`timescale 1ns/1ns
module crf_formatter_tb;
  import crf_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_start = 0, go = 0, o_busy, o_done, rbusy;
  crf_req_t i_req = '0;
  logic [6:0] ra;
  logic [15:0] rdat;
  logic [15:0] mem [128];
  int error_cnt = 0, tests_run = 0;
  crf_formatter dut_u (.i_clk, .i_resetn, .i_start, .i_req, .i_rd_addr(ra), .o_rd_data(rdat), .o_busy, .o_done);
  crf_reader rd_u (.i_clk, .i_go(go), .i_rd_data(rdat), .o_rd_addr(ra), .o_mem(mem), .o_busy(rbusy));
  initial forever #5 i_clk = ~i_clk;
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (exp !== got) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] exp_w(crf_req_t r, int a);
    logic [15:0] d [3];
    d = '{r.detail1, r.detail2, r.detail3};
    if (r.ok) return (a == 7) ? {r.diag_type, r.diag_len} : 16'h0000;
    if (a == 0) return r.err_code;
    if (a == 1) return {9'h000, r.station};
    if (a < 5) return (r.err_code === CRF_REJECT_CODE) ? d[a-2] : CRF_NO_DETAIL;
    return CRF_ZERO;
  endfunction
  // the second start lands while busy and must leave the first request alone
  // outputs are judged at the falling edge, where they have settled
  task automatic run(crf_req_t r);
    int k;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_req <= r;
    @(posedge i_clk);
    i_req <= ~r;
    @(negedge i_clk);
    chk("busy_rise", 16'h0001, 16'(o_busy));
    @(posedge i_clk);
    i_start <= 1'b0;
    @(negedge i_clk);
    for (k = 1; k < 200 && o_done !== 1'b1; k++) @(negedge i_clk);
    chk("done_edge", 16'(CRF_WORDS + 1), 16'(k));
    chk("busy_fall", 16'h0000, 16'(o_busy));
    if (k == 200) return;
    @(posedge i_clk);
    go <= 1'b1;
    @(negedge i_clk);
    chk("done_pulse", 16'h0000, 16'(o_done));
    @(posedge i_clk);
    go <= 1'b0;
    @(negedge i_clk);
    for (k = 0; k < 200 && rbusy; k++) @(negedge i_clk);
    if (k == 200) begin
      chk("read_end", 16'h0001, 16'h0000);
      return;
    end
    for (k = 0; k < 128; k++) chk($sformatf("word%0d", k), exp_w(r, k), mem[k]);
  endtask
  // reset in the middle of a fill drops every flag at once and keeps the block idle after release
  task automatic s_reset;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_req <= '{1'b1, 16'h0000, 7'h01, 16'h0000, 16'h0000, 16'h0000, 8'h5A, 8'hC3};
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
    chk("rst_busy", 16'h0000, 16'(o_busy));
    chk("rst_done", 16'h0000, 16'(o_done));
    chk("rst_data", CRF_ZERO, rdat);
    @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) begin
      @(posedge i_clk);
      @(negedge i_clk);
      chk("rel_busy", 16'h0000, 16'(o_busy));
      chk("rel_done", 16'h0000, 16'(o_done));
    end
  endtask
  task s_ok;
    run('{1'b1, 16'h1234, 7'h05, 16'h1111, 16'h2222, 16'h3333, 8'hA5, 8'h3C});
  endtask
  task s_rej;
    run('{1'b0, 16'hE482, 7'h7D, 16'h0A01, 16'h0B02, 16'h0C03, 8'hFF, 8'hFF});
  endtask
  task s_other;
    run('{1'b0, 16'hE483, 7'h00, 16'h0A01, 16'h0B02, 16'h0C03, 8'h11, 8'h22});
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1;
    s_ok();
    s_rej();
    s_reset();
    s_other();
    end_sim();
  end
endmodule
